// *** hw/ppx_datapath.sv ***
// Logical and replace instruction datapath of the peripheral processor
`timescale 1ns/1ps
// What this block does
// - Selective clear zeros marked low accumulator bits
// - Short XOR flips marked low six bits
// - Long XOR uses field and next word
// - Direct XOR into low twelve bits
// - Indirect XOR via pointer word, low twelve
// - Indexed XOR into low twelve bits
// - Indexed address: base plus indexed content if nonzero
// - Short AND clears upper twelve bits
// - Long AND with field and next word
// - Replace writes low twelve bits, accumulator full
// - Replace arithmetic is one's complement
// - Direct replace-add stores sum to operand
// - Direct increment stores value plus one
// - Indirect replace-add stores sum over operand
// - Indirect/indexed increment store value plus one
// - Direct decrement stores value minus one
// - Indirect/indexed decrement store value minus one
// - Opcodes 01 to 07 form branch group
// - Decode six channel-conditional jump opcodes
module ppx_datapath
	import ppx_pkg::*;
#(
	parameter int MEM_DEPTH = 4096
)(
	input  wire logic               ref_clk,     // Clock
	input  wire logic               resetn,      // Sync reset, active low
	input  wire logic               start,       // Pulse: execute instruction
	input  wire logic [11:0]        instr,       // Instruction word at P
	input  wire logic [11:0]        next_word,   // Word at P plus 1
	output logic                    busy_ff,     // Instruction in progress
	output logic                    done_ff,     // Pulse: instruction finished
	output logic                    unsupp_ff,   // Pulse: opcode not handled here
	output logic                    branch_ff,   // Pulse: branch group decoded
	output logic [2:0]              chan_jump_ff,// Channel jump kind, 0 none
	output logic [ACC_W-1:0]        acc_ff       // Accumulator
);
	typedef enum {ST_IDLE, ST_RD_D, ST_RD_PTR, ST_RD_OPND, ST_WAIT, ST_EXEC} ppx_state_t;

	ppx_mem_if mem ();

	ppx_local_mem #(.DEPTH(MEM_DEPTH)) u_mem (
		.ref_clk (ref_clk),
		.mem     (mem)
	);

	ppx_state_t        state_ff;
	ppx_state_t        nxt_state;
	ppx_opkind_t       kind_ff;
	ppx_amode_t        amode_ff;
	logic [5:0]        field_ff;
	logic [11:0]       base_ff;
	logic [11:0]       addr_ff;
	logic [11:0]       opnd_ff;

	// Decode of the incoming instruction
	wire logic [5:0]   op      = instr[11:6];
	wire logic [5:0]   fld     = instr[5:0];
	wire logic [8:0]   op9     = instr[11:3];
	wire logic         is_br   = (op >= OP_FAR_JUMP) && (op <= OP_BRANCH_LAST);
	wire logic         is_chan = (op >= OP_CHAN_HI) && (op <= OP_CHAN_TOP);
	logic [2:0]        chan_code;
	ppx_opkind_t       dk;
	ppx_amode_t        dm;

	always_comb
	begin
		chan_code = 3'h0;
		case (op9)
			OP_JMP_ACTIVE:    chan_code = 3'h1;
			OP_JMP_INACTIVE:  chan_code = 3'h2;
			OP_JMP_FULL:      chan_code = 3'h3;
			OP_JMP_ERR_SET:   chan_code = 3'h4;
			OP_JMP_EMPTY:     chan_code = 3'h5;
			OP_JMP_ERR_CLEAR: chan_code = 3'h6;
			default:          chan_code = 3'h0;
		endcase
	end

	always_comb
	begin
		dk = PPX_OK_NONE;
		dm = PPX_AM_IMM;
		case (op)
			OP_SEL_CLEAR:   dk = PPX_OK_CLR;
			OP_XOR_SHORT:   dk = PPX_OK_XOR;
			OP_XOR_LONG:    dk = PPX_OK_XOR;
			OP_AND_SHORT:   dk = PPX_OK_AND;
			OP_AND_LONG:    dk = PPX_OK_AND;
			OP_XOR_DIRECT:
			begin
				dk = PPX_OK_XOR;
				dm = PPX_AM_DIR;
			end
			OP_XOR_INDIR:
			begin
				dk = PPX_OK_XOR;
				dm = PPX_AM_IND;
			end
			OP_XOR_INDEX:
			begin
				dk = PPX_OK_XOR;
				dm = PPX_AM_IDX;
			end
			OP_RADD_DIRECT:
			begin
				dk = PPX_OK_RADD;
				dm = PPX_AM_DIR;
			end
			OP_RADD_INDIR:
			begin
				dk = PPX_OK_RADD;
				dm = PPX_AM_IND;
			end
			OP_RADD_INDEX:
			begin
				dk = PPX_OK_RADD;
				dm = PPX_AM_IDX;
			end
			OP_INC_DIRECT:
			begin
				dk = PPX_OK_INC;
				dm = PPX_AM_DIR;
			end
			OP_INC_INDIR:
			begin
				dk = PPX_OK_INC;
				dm = PPX_AM_IND;
			end
			OP_INC_INDEX:
			begin
				dk = PPX_OK_INC;
				dm = PPX_AM_IDX;
			end
			OP_DEC_DIRECT:
			begin
				dk = PPX_OK_DEC;
				dm = PPX_AM_DIR;
			end
			OP_DEC_INDIR:
			begin
				dk = PPX_OK_DEC;
				dm = PPX_AM_IND;
			end
			OP_DEC_INDEX:
			begin
				dk = PPX_OK_DEC;
				dm = PPX_AM_IDX;
			end
			default:        dk = PPX_OK_NONE;
		endcase
	end

	// Immediate operand: short forms use field, long forms field and next word
	wire logic         long_imm = (op == OP_XOR_LONG) || (op == OP_AND_LONG);
	wire logic [17:0]  imm_val  = long_imm ? {fld, next_word}
	                                       : {12'h000, fld};
	wire logic [17:0]  imm_res  =
		(dk == PPX_OK_CLR) ? (acc_ff & ~{12'h000, fld}) :
		(dk == PPX_OK_XOR) ? (acc_ff ^ imm_val) :
		long_imm           ? (acc_ff & imm_val) :
		                     {12'h000, acc_ff[5:0] & fld};

	// Replace arithmetic on the 12-bit positive operand
	wire logic [17:0]  opnd_ext = {6'h00, opnd_ff};
	wire logic [17:0]  add_b    =
		(kind_ff == PPX_OK_RADD) ? acc_ff :
		(kind_ff == PPX_OK_INC)  ? 18'h00001 :
		                           18'h3fffe;
	logic [17:0]       sum;

	ppx_ones_adder #(.W(ACC_W)) u_add (
		.a   (opnd_ext),
		.b   (add_b),
		.sum (sum)
	);

	wire logic         is_repl  = (kind_ff == PPX_OK_RADD) || (kind_ff == PPX_OK_INC) ||
	                              (kind_ff == PPX_OK_DEC);
	wire logic [17:0]  xor_res  = {acc_ff[17:12], acc_ff[11:0] ^ opnd_ff};

	// Indexed address: base alone when field is zero
	wire logic [11:0]  idx_addr = base_ff + mem.rdata;

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE:
				if (start && dk != PPX_OK_NONE && dm != PPX_AM_IMM)
					nxt_state = ST_RD_D;
			ST_RD_D:    nxt_state = ST_RD_PTR;
			ST_RD_PTR:  nxt_state = ST_RD_OPND;
			ST_RD_OPND: nxt_state = ST_WAIT;
			ST_WAIT:    nxt_state = ST_EXEC;
			ST_EXEC:    nxt_state = ST_IDLE;
			default:    nxt_state = ST_IDLE;
		endcase
	end

	// Memory port: field read, then operand read, then write-back
	assign mem.rd    = (state_ff == ST_RD_D) || (state_ff == ST_RD_OPND);
	assign mem.addr  = (state_ff == ST_RD_D)    ? {6'h00, field_ff} :
	                   (state_ff == ST_RD_OPND) ? addr_ff : addr_ff;
	assign mem.wr    = (state_ff == ST_EXEC) && is_repl;
	assign mem.wdata = sum[WORD_W-1:0];

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			state_ff     <= ST_IDLE;
			kind_ff      <= PPX_OK_NONE;
			amode_ff     <= PPX_AM_IMM;
			field_ff     <= 6'h00;
			base_ff      <= ADDR_RST;
			addr_ff      <= ADDR_RST;
			opnd_ff      <= ADDR_RST;
			acc_ff       <= ACC_RST;
			busy_ff      <= 1'b0;
			done_ff      <= 1'b0;
			unsupp_ff    <= 1'b0;
			branch_ff    <= 1'b0;
			chan_jump_ff <= 3'h0;
		end
		else
		begin
			state_ff     <= nxt_state;
			done_ff      <= 1'b0;
			unsupp_ff    <= 1'b0;
			branch_ff    <= 1'b0;
			chan_jump_ff <= 3'h0;
			case (state_ff)
				ST_IDLE:
					if (start)
					begin
						kind_ff  <= dk;
						amode_ff <= dm;
						field_ff <= fld;
						base_ff  <= next_word;
						if (dk != PPX_OK_NONE && dm == PPX_AM_IMM)
						begin
							acc_ff  <= imm_res;
							done_ff <= 1'b1;
						end
						else if (dk != PPX_OK_NONE)
							busy_ff <= 1'b1;
						else
						begin
							branch_ff    <= is_br;
							chan_jump_ff <= is_chan ? chan_code : 3'h0;
							unsupp_ff    <= 1'b1;
						end
					end
				ST_RD_PTR:
				begin
					// Location d read; its data is valid now
					case (amode_ff)
						PPX_AM_DIR: addr_ff <= {6'h00, field_ff};
						PPX_AM_IND: addr_ff <= mem.rdata;
						PPX_AM_IDX: addr_ff <= (field_ff == 6'h00) ? base_ff
						                                         : idx_addr;
						default:    addr_ff <= {6'h00, field_ff};
					endcase
				end
				ST_WAIT:
					opnd_ff <= mem.rdata;
				ST_EXEC:
				begin
					acc_ff  <= is_repl ? sum : xor_res;
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
				end
				default: ;
			endcase
		end
	end
endmodule

// *** hw/ppx_pkg.sv ***
// Package: opcodes, widths and reset values of the logical/replace datapath
package ppx_pkg;
	localparam int ACC_W    = 18;
	localparam int WORD_W   = 12;
	localparam int FIELD_W  = 6;
	localparam int LONG_W   = 16;
	localparam logic [ACC_W-1:0]  ACC_RST  = 18'h00000;
	localparam logic [WORD_W-1:0] ADDR_RST = 12'h000;
	// Six-bit opcodes (octal values shown in hex)
	localparam logic [5:0] OP_FAR_JUMP    = 6'h01; // octal 01
	localparam logic [5:0] OP_BRANCH_LAST = 6'h07; // octal 07
	localparam logic [5:0] OP_SEL_CLEAR   = 6'h0b; // octal 13
	localparam logic [5:0] OP_XOR_SHORT   = 6'h09; // octal 11
	localparam logic [5:0] OP_AND_SHORT   = 6'h0a; // octal 12
	localparam logic [5:0] OP_AND_LONG    = 6'h12; // octal 22
	localparam logic [5:0] OP_XOR_LONG    = 6'h13; // octal 23
	localparam logic [5:0] OP_XOR_DIRECT  = 6'h1b; // octal 33
	localparam logic [5:0] OP_RADD_DIRECT = 6'h1d; // octal 35
	localparam logic [5:0] OP_INC_DIRECT  = 6'h1e; // octal 36
	localparam logic [5:0] OP_DEC_DIRECT  = 6'h1f; // octal 37
	localparam logic [5:0] OP_XOR_INDIR   = 6'h23; // octal 43
	localparam logic [5:0] OP_RADD_INDIR  = 6'h25; // octal 45
	localparam logic [5:0] OP_INC_INDIR   = 6'h26; // octal 46
	localparam logic [5:0] OP_DEC_INDIR   = 6'h27; // octal 47
	localparam logic [5:0] OP_XOR_INDEX   = 6'h2b; // octal 53
	localparam logic [5:0] OP_RADD_INDEX  = 6'h2d; // octal 55
	localparam logic [5:0] OP_INC_INDEX   = 6'h2e; // octal 56
	localparam logic [5:0] OP_DEC_INDEX   = 6'h2f; // octal 57
	localparam logic [5:0] OP_CHAN_HI     = 6'h34; // octal 64..67 leading six bits
	localparam logic [5:0] OP_CHAN_TOP    = 6'h37;
	// Nine-bit channel jump opcodes
	localparam logic [8:0] OP_JMP_ACTIVE    = 9'h1a0; // octal 640
	localparam logic [8:0] OP_JMP_INACTIVE  = 9'h1a8; // octal 650
	localparam logic [8:0] OP_JMP_FULL      = 9'h1b0; // octal 660
	localparam logic [8:0] OP_JMP_ERR_SET   = 9'h1b1; // octal 661
	localparam logic [8:0] OP_JMP_EMPTY     = 9'h1b8; // octal 670
	localparam logic [8:0] OP_JMP_ERR_CLEAR = 9'h1b9; // octal 671
	typedef enum logic [2:0] {PPX_OK_NONE, PPX_OK_XOR, PPX_OK_AND, PPX_OK_CLR,
		PPX_OK_RADD, PPX_OK_INC, PPX_OK_DEC} ppx_opkind_t;
	typedef enum logic [1:0] {PPX_AM_IMM, PPX_AM_DIR, PPX_AM_IND, PPX_AM_IDX} ppx_amode_t;
endpackage

// *** hw/ppx_mem_if.sv ***
// Interface: processor local memory port between datapath and its memory
`timescale 1ns/1ps
interface ppx_mem_if;
	import ppx_pkg::*;
	logic [WORD_W-1:0] addr;
	logic              rd;
	logic              wr;
	logic [WORD_W-1:0] wdata;
	logic [WORD_W-1:0] rdata;
	modport master (output addr, rd, wr, wdata, input rdata);
	modport slave  (input addr, rd, wr, wdata, output rdata);
endinterface

// *** hw/ppx_local_mem.sv ***
// Processor local memory with registered read data
`timescale 1ns/1ps
module ppx_local_mem
	import ppx_pkg::*;
#(
	parameter int DEPTH = 4096
)(
	input  wire logic ref_clk, // Clock
	ppx_mem_if.slave  mem      // Memory port
);
	logic [WORD_W-1:0] store [DEPTH];
	logic [WORD_W-1:0] rdata_ff;

	always_ff @(posedge ref_clk)
	begin
		if (mem.wr)
			store[mem.addr] <= mem.wdata;
		if (mem.rd)
			rdata_ff <= store[mem.addr];
	end
	assign mem.rdata = rdata_ff;
endmodule

// *** hw/ppx_ones_adder.sv ***
// One's complement adder with end-around carry
`timescale 1ns/1ps
module ppx_ones_adder
#(
	parameter int W = 18
)(
	input  wire logic [W-1:0] a,   // Addend
	input  wire logic [W-1:0] b,   // Addend
	output logic      [W-1:0] sum  // One's complement sum
);
	logic [W:0] raw;
	assign raw = {1'b0, a} + {1'b0, b};
	assign sum = raw[W-1:0] + {{(W-1){1'b0}}, raw[W]};
endmodule

// *** verif/ppx_datapath_asserts.sv ***
// Assertion checker for the logical and replace datapath
`timescale 1ns/1ps
module ppx_datapath_chk
	import ppx_pkg::*;
(
	input wire logic             ref_clk,      // Clock
	input wire logic             resetn,       // Reset
	input wire logic             start,        // Start
	input wire logic [11:0]      instr,        // Instruction
	input wire logic [11:0]      next_word,    // Word m
	input wire logic             busy_ff,      // Busy
	input wire logic             done_ff,      // Done
	input wire logic             unsupp_ff,    // Not handled
	input wire logic             branch_ff,    // Branch group
	input wire logic [2:0]       chan_jump_ff, // Channel jump
	input wire logic [ACC_W-1:0] acc_ff        // Accumulator
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	wire logic       tk = start && !busy_ff;
	wire logic [5:0] op = instr[11:6];
	property p_clr;
		tk && op == OP_SEL_CLEAR |=> acc_ff == ($past(acc_ff) & ~{12'h000, $past(instr[5:0])});
	endproperty
	a_clr: assert property (p_clr) else $error("clear result");
	property p_xs;
		tk && op == OP_XOR_SHORT |=> acc_ff == ($past(acc_ff) ^ {12'h000, $past(instr[5:0])});
	endproperty
	a_xs: assert property (p_xs) else $error("short xor result");
	property p_xl;
		tk && op == OP_XOR_LONG |=> acc_ff == ($past(acc_ff) ^ {$past(instr[5:0]), $past(next_word)});
	endproperty
	a_xl: assert property (p_xl) else $error("long xor result");
	property p_as;
		tk && op == OP_AND_SHORT |=> acc_ff == {12'h000, $past(acc_ff[5:0]) & $past(instr[5:0])};
	endproperty
	a_as: assert property (p_as) else $error("short and result");
	property p_al;
		tk && op == OP_AND_LONG |=> acc_ff == ($past(acc_ff) & {$past(instr[5:0]), $past(next_word)});
	endproperty
	a_al: assert property (p_al) else $error("long and result");
	property p_xd;
		tk && op == OP_XOR_DIRECT |=> busy_ff [*5] ##1
			(done_ff && !busy_ff && acc_ff[17:12] == $past(acc_ff[17:12], 6));
	endproperty
	a_xd: assert property (p_xd) else $error("direct xor sequence");
	property p_br;
		tk && op >= OP_FAR_JUMP && op <= OP_BRANCH_LAST |=> branch_ff && unsupp_ff && !done_ff;
	endproperty
	a_br: assert property (p_br) else $error("branch decode");
	property p_ch;
		tk && instr[11:3] == OP_JMP_ERR_SET |=> unsupp_ff && chan_jump_ff == 3'h4;
	endproperty
	a_ch: assert property (p_ch) else $error("channel jump decode");
endmodule
bind ppx_datapath ppx_datapath_chk i_chk (.ref_clk(ref_clk), .resetn(resetn), .start(start),
	.instr(instr), .next_word(next_word), .busy_ff(busy_ff), .done_ff(done_ff),
	.unsupp_ff(unsupp_ff), .branch_ff(branch_ff), .chan_jump_ff(chan_jump_ff), .acc_ff(acc_ff));

// *** verif/test_ppx_datapath.sv ***
// Self-checking bench for the logical and replace datapath
`timescale 1ns/1ps
module test_ppx_datapath;
	import ppx_pkg::*;
	logic             ref_clk = 1'h0;
	logic             resetn = 1'h0;
	logic             start = 1'h0;
	logic [11:0]      instr = 12'h000;
	logic [11:0]      next_word = 12'h000;
	logic             busy_ff, done_ff, unsupp_ff, branch_ff;
	logic [2:0]       chan_jump_ff;
	logic [ACC_W-1:0] acc_ff, ea;
	logic [11:0]      mdl [4096];
	logic [11:0]      r;
	int               num_errors = 0;
	int               n_tests = 0;
	logic [8:0]       cj [6] = '{OP_JMP_ACTIVE, OP_JMP_INACTIVE, OP_JMP_FULL,
		OP_JMP_ERR_SET, OP_JMP_EMPTY, OP_JMP_ERR_CLEAR};
	logic [5:0]       ops [30] = '{6'h0b, 6'h09, 6'h0a, 6'h12, 6'h13, 6'h1b, 6'h1d, 6'h1e,
		6'h1f, 6'h23, 6'h25, 6'h26, 6'h27, 6'h2b, 6'h2d, 6'h2e, 6'h2f, 6'h01, 6'h02, 6'h03,
		6'h04, 6'h05, 6'h06, 6'h07, 6'h34, 6'h35, 6'h36, 6'h37, 6'h08, 6'h3c};

	ppx_datapath i_dut (.ref_clk(ref_clk), .resetn(resetn), .start(start), .instr(instr),
		.next_word(next_word), .busy_ff(busy_ff), .done_ff(done_ff), .unsupp_ff(unsupp_ff),
		.branch_ff(branch_ff), .chan_jump_ff(chan_jump_ff), .acc_ff(acc_ff));

	initial forever #5 ref_clk = ~ref_clk;

	task automatic check(logic [ACC_W-1:0] seen, logic [ACC_W-1:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		if (num_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// One's complement sum with end-around carry
	function automatic logic [17:0] oadd(logic [17:0] a, logic [17:0] b);
		logic [18:0] s;
		s = a + b;
		return s[17:0] + 18'(s[18]);
	endfunction

	function automatic logic [2:0] chan(logic [8:0] c);
		foreach (cj[i])
			if (c == cj[i])
				return 3'(i + 1);
		return 3'h0;
	endfunction

	task automatic poke(logic [11:0] a, logic [11:0] v);
		mdl[a] = v;
		i_dut.u_mem.store[a] = v;
	endtask

	task automatic run(logic [11:0] ins, logic [11:0] m);
		logic [5:0]  op;
		logic [5:0]  d;
		logic [11:0] a;
		logic        mem;
		logic        hd;
		int          k;
		op = ins[11:6];
		d = ins[5:0];
		mem = op[5:3] inside {3'h3, 3'h4, 3'h5} && op[2:0] inside {3'h3, 3'h5, 3'h6, 3'h7};
		hd = mem || op inside {6'h0b, 6'h09, 6'h13, 6'h0a, 6'h12};
		a = op[5:3] == 3'h3 ? {6'h00, d} : op[5:3] == 3'h4 ? mdl[d] : d == 6'h00 ? m : m + mdl[d];
		instr = ins;
		next_word = m;
		start = 1'h1;
		@(posedge ref_clk);
		#1 start = 1'h0;
		case (op)
			6'h0b: ea[5:0] &= ~d;
			6'h09: ea[5:0] ^= d;
			6'h13: ea ^= {d, m};
			6'h0a: ea = {12'h000, ea[5:0] & d};
			6'h12: ea &= {d, m};
			6'h1b, 6'h23, 6'h2b: ea[11:0] ^= mdl[a];
			6'h1d, 6'h25, 6'h2d: ea = oadd(ea, {6'h00, mdl[a]});
			6'h1e, 6'h26, 6'h2e: ea = oadd({6'h00, mdl[a]}, 18'h00001);
			6'h1f, 6'h27, 6'h2f: ea = oadd({6'h00, mdl[a]}, 18'h3fffe);
			default: ;
		endcase
		if (mem && op[2:0] != 3'h3)
			mdl[a] = ea[11:0];
		for (k = 0; k < 12 && done_ff !== 1'h1 && unsupp_ff !== 1'h1; k++)
		begin
			// Second start while busy must be ignored
			start = (k == 1);
			@(posedge ref_clk);
			#1;
		end
		start = 1'h0;
		if (k == 12)
		begin
			num_errors++;
			summarize();
		end
		check(acc_ff, ea);
		check(18'({done_ff, unsupp_ff, branch_ff, chan_jump_ff}),
			18'({hd, !hd, op >= 6'h01 && op <= 6'h07, chan(ins[11:3])}));
		if (mem)
			check(18'(i_dut.u_mem.store[a]), 18'(mdl[a]));
	endtask

	initial
	begin
		void'($urandom(52));
		for (int i = 0; i < 4096; i++)
			poke(12'(i), 12'($urandom));
		ea = ACC_RST;
		repeat (4) @(posedge ref_clk);
		#1 resetn = 1'h1;
		check(acc_ff, ACC_RST);
		poke(12'h005, 12'hfff);
		run({6'h1e, 6'h05}, 12'h000);
		run({6'h1f, 6'h05}, 12'h000);
		poke(12'h007, 12'hfff);
		run({6'h2b, 6'h07}, 12'h002);
		run({6'h2d, 6'h00}, 12'h123);
		repeat (400)
		begin
			r = {ops[$urandom % 30], 6'($urandom)};
			if (r[11:9] == 3'h6 && r[0])
				r[11:3] = cj[$urandom % 6];
			run(r, 12'($urandom));
		end
		summarize();
	end
endmodule
